/* include/pwm_cfg.svh */
// constants for the sawtooth pwm block with dead time
// assumes inclusion by bare name from include/
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

// ****************************************************************
// widths
// ****************************************************************
`define CNT_W 16
`define DT_W 12
`define CH_N 3
`define CMP_N 5
`define ADDR_W 8

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_TIMER_CONTROL 8'h00
`define OFS_OUTPUT_MODE 8'h04
`define OFS_PERIOD_BUFFER 8'h08
`define OFS_DUTY_BUFFER_0 8'h0C
`define OFS_DEAD_TIME_RELOAD 8'h20
`define OFS_PWM_COUNTER 8'h24
`define OFS_PERIOD_COMPARE 8'h28
`define OFS_DUTY_COMPARE_0 8'h2C
`define OFS_STATUS 8'h40

// ****************************************************************
// field layout and reset values
// ****************************************************************
`define CTRL_W 9
`define OMODE_W 2
`define PRESCALE_MAX 3'h5
`define DT_IDLE 12'hFFF
`define DT_ZERO 12'h000
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define PRESC_W 5

`endif

/* include/pwm_pkg.sv */
// types for the sawtooth pwm block with dead time
// assumes pwm_cfg.svh is on the include path
`include "pwm_cfg.svh"

package pwm_pkg;

	// ****************************************************************
	// modes and register layouts
	// ****************************************************************
	typedef enum logic [1:0] {
		MODE_TRI_SYM,
		MODE_TRI_ASYM,
		MODE_SAW,
		MODE_RSVD
	} mode_t;

	typedef struct packed {
		logic count_enable_bit;
		logic dead_time_disable;
		logic duty_xfer_enable;
		logic period_xfer_enable;
		logic [2:0] prescale_sel;
		mode_t mode_select;
	} timer_control_t;

	typedef struct packed {
		logic pins_enable;
		logic output_polarity_bit;
	} output_mode_t;

	// ****************************************************************
	// whole block state
	// ****************************************************************
	typedef struct packed {
		timer_control_t ctrl;
		output_mode_t omode;
		logic [`CNT_W-1:0] period_buffer;
		logic [`CNT_W-1:0] period_compare;
		logic [`CMP_N-1:0][`CNT_W-1:0] duty_buffer;
		logic [`CMP_N-1:0][`CNT_W-1:0] duty_compare;
		logic [`DT_W-1:0] dead_time_reload;
		logic [`CNT_W-1:0] pwm_counter;
		logic count_down;
		logic [`PRESC_W-1:0] presc;
		logic ce_prev;
		logic [`CH_N-1:0] phase_ff;
		logic [`CH_N-1:0][`DT_W-1:0] dead_time_timer;
		logic [`CH_N-1:0] pos_pin;
		logic [`CH_N-1:0] neg_pin;
		logic period_irq;
		logic under_irq;
		logic [`CMP_N-1:0] duty_irq;
		logic [31:0] rdata;
	} state_t;

endpackage

/* core/sawtooth_pwm_dead_time.sv */
// six-output pwm generator: sawtooth and triangular counting, dead time
// assumes a plain register port and gate drivers on the six pins
`include "pwm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sawtooth_pwm_dead_time #(
	parameter bit IS_UNIT0 = 1'b0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// pwm pins, enable low while driving
	output logic [`CH_N-1:0] pwm_out_positive,
	output logic [`CH_N-1:0] pwm_out_negative,
	output logic [`CH_N-1:0] pwm_positive_oe_n,
	output logic [`CH_N-1:0] pwm_negative_oe_n,
	// events, one-cycle pulses
	output logic period_match_irq,
	output logic underflow_irq,
	output logic [`CMP_N-1:0] duty_match_irq
);

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	// slot 0..4 of a block of compare words, or 7 when outside it
	function automatic logic [2:0] slot_of(
		input logic [`ADDR_W-1:0] addr,
		input logic [`ADDR_W-1:0] base
	);
		logic [`ADDR_W-1:0] d;
		d = addr - base;
		if (addr >= base && d[1:0] == 2'b00 && d[`ADDR_W-1:2] < `CMP_N)
			slot_of = d[4:2];
		else
			slot_of = 3'h7;
	endfunction

	// counts of base clocks per count tick are 1,2,4,8,16,32
	function automatic logic [`PRESC_W-1:0] tick_mask(
		input logic [2:0] sel
	);
		logic [2:0] s;
		s = (sel > `PRESCALE_MAX) ? `PRESCALE_MAX : sel;
		tick_mask = `PRESC_W'((6'h01 << s) - 6'h01);
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	pwm_pkg::state_t s;
	pwm_pkg::state_t next_s;

	logic [2:0] wslot;
	logic [2:0] rslot;
	logic [2:0] cslot;
	logic start;
	logic tick;
	logic saw;
	logic top;
	logic bottom;
	logic period_hit;
	logic xfer_now;
	logic [`CNT_W-1:0] duty_eff;
	logic [`CMP_N-1:0] duty_hit;
	logic [`CH_N-1:0] pos_act;
	logic [`CH_N-1:0] neg_act;

	always_comb begin
		next_s = s;
		wslot = slot_of(reg_addr, `OFS_DUTY_BUFFER_0);
		rslot = slot_of(reg_addr, `OFS_DUTY_BUFFER_0);
		cslot = slot_of(reg_addr, `OFS_DUTY_COMPARE_0);
		start = 1'b0;
		tick = 1'b0;
		saw = 1'b0;
		top = 1'b0;
		bottom = 1'b0;
		period_hit = 1'b0;
		xfer_now = 1'b0;
		duty_eff = `CNT_ZERO;
		duty_hit = '0;
		pos_act = '0;
		neg_act = '0;

		// ************************************************************
		// register writes
		// ************************************************************
		if (reg_wr) begin
			if (reg_addr == `OFS_TIMER_CONTROL) begin
				next_s.ctrl = pwm_pkg::timer_control_t'(reg_wdata[`CTRL_W-1:0]);
			end else if (reg_addr == `OFS_OUTPUT_MODE) begin
				next_s.omode = pwm_pkg::output_mode_t'(reg_wdata[`OMODE_W-1:0]);
			end else if (reg_addr == `OFS_PERIOD_BUFFER) begin
				next_s.period_buffer = reg_wdata[`CNT_W-1:0];
				// without transfer the compare follows the buffer at once
				if (!s.ctrl.period_xfer_enable)
					next_s.period_compare = reg_wdata[`CNT_W-1:0];
			end else if (reg_addr == `OFS_DEAD_TIME_RELOAD) begin
				next_s.dead_time_reload = reg_wdata[`DT_W-1:0];
			end else if (wslot != 3'h7) begin
				next_s.duty_buffer[wslot] = reg_wdata[`CNT_W-1:0];
				if (!s.ctrl.duty_xfer_enable)
					next_s.duty_compare[wslot] = reg_wdata[`CNT_W-1:0];
			end
		end

		// ************************************************************
		// register reads, data stand one cycle only
		// ************************************************************
		next_s.rdata = 32'h0000_0000;
		if (reg_rd) begin
			if (reg_addr == `OFS_TIMER_CONTROL)
				next_s.rdata[`CTRL_W-1:0] = s.ctrl;
			else if (reg_addr == `OFS_OUTPUT_MODE)
				next_s.rdata[`OMODE_W-1:0] = s.omode;
			else if (reg_addr == `OFS_PERIOD_BUFFER)
				next_s.rdata[`CNT_W-1:0] = s.period_buffer;
			else if (reg_addr == `OFS_DEAD_TIME_RELOAD)
				next_s.rdata[`DT_W-1:0] = s.dead_time_reload;
			else if (reg_addr == `OFS_PWM_COUNTER)
				next_s.rdata[`CNT_W-1:0] = s.pwm_counter;
			else if (reg_addr == `OFS_PERIOD_COMPARE)
				next_s.rdata[`CNT_W-1:0] = s.period_compare;
			else if (reg_addr == `OFS_STATUS)
				next_s.rdata[7:0] = {1'b0, s.count_down, s.neg_pin[2],
					s.pos_pin[2], 1'b0, s.phase_ff};
			else if (rslot != 3'h7)
				next_s.rdata[`CNT_W-1:0] = s.duty_buffer[rslot];
			else if (cslot != 3'h7)
				next_s.rdata[`CNT_W-1:0] = s.duty_compare[cslot];
		end

		// ************************************************************
		// counter and prescaler
		// ************************************************************
		saw = (s.ctrl.mode_select == pwm_pkg::MODE_SAW);
		start = s.ctrl.count_enable_bit & ~s.ce_prev;
		next_s.ce_prev = s.ctrl.count_enable_bit;
		tick = s.ctrl.count_enable_bit & ~start &
			((s.presc & tick_mask(s.ctrl.prescale_sel)) ==
			tick_mask(s.ctrl.prescale_sel));
		next_s.presc = s.ctrl.count_enable_bit ?
			`PRESC_W'(s.presc + `PRESC_W'(1)) : '0;
		next_s.period_irq = 1'b0;
		next_s.under_irq = 1'b0;
		next_s.duty_irq = '0;

		// zero period is never written by software
		top = (s.pwm_counter == s.period_compare) &&
			(saw || !s.count_down);
		bottom = (s.pwm_counter == `CNT_ZERO) && s.count_down && !saw;
		period_hit = tick & top;

		// which events copy buffers into compares
		unique case (s.ctrl.mode_select)
			pwm_pkg::MODE_SAW: xfer_now = period_hit;
			pwm_pkg::MODE_TRI_ASYM: xfer_now = period_hit | (tick & bottom);
			pwm_pkg::MODE_TRI_SYM: xfer_now = tick & bottom;
			default: xfer_now = 1'b0;
		endcase

		if (!s.ctrl.count_enable_bit) begin
			// stopped: positive idle, negative active
			next_s.pwm_counter = `CNT_ZERO;
			next_s.count_down = 1'b0;
			next_s.phase_ff = '0;
		end else if (start) begin
			next_s.pwm_counter = `CNT_ZERO;
			next_s.count_down = 1'b0;
			next_s.phase_ff = '1;
		end else if (tick) begin
			// counter runs 0..period: period+1 counts in sawtooth, 2*period in triangle
			if (saw) begin
				if (top) begin
					next_s.pwm_counter = `CNT_ZERO;
					next_s.period_irq = 1'b1;
				end else begin
					next_s.pwm_counter = s.pwm_counter + `CNT_ONE;
				end
			end else if (top) begin
				next_s.count_down = 1'b1;
				next_s.pwm_counter = s.pwm_counter - `CNT_ONE;
				next_s.period_irq = 1'b1;
			end else if (bottom) begin
				next_s.count_down = 1'b0;
				next_s.pwm_counter = s.pwm_counter + `CNT_ONE;
				next_s.under_irq = 1'b1;
			end else begin
				next_s.pwm_counter = s.count_down ?
					s.pwm_counter - `CNT_ONE : s.pwm_counter + `CNT_ONE;
			end

			// duty matches use a value copied in this very cycle
			for (int c = 0; c < `CMP_N; c++) begin
				duty_eff = (xfer_now && s.ctrl.duty_xfer_enable) ?
					s.duty_buffer[c] : s.duty_compare[c];
				duty_hit[c] = (s.pwm_counter == duty_eff);
			end

			// phase flip-flops, reset has priority over set
			for (int c = 0; c < `CH_N; c++) begin
				if (saw) begin
					if (duty_hit[c])
						next_s.phase_ff[c] = 1'b0;
					else if (top)
						next_s.phase_ff[c] = 1'b1;
					// no match above period: flip-flop holds
				end else if (duty_hit[c]) begin
					// at the top the match counts as falling
					next_s.phase_ff[c] = !(s.count_down || top);
				end
			end

			// duty events; above-period values never match
			for (int c = 0; c < `CMP_N; c++) begin
				if (!(IS_UNIT0 && c < `CH_N))
					next_s.duty_irq[c] = duty_hit[c];
			end
		end

		// ************************************************************
		// buffer transfer
		// ************************************************************
		if (xfer_now) begin
			if (s.ctrl.period_xfer_enable)
				next_s.period_compare = s.period_buffer;
			if (s.ctrl.duty_xfer_enable)
				next_s.duty_compare = s.duty_buffer;
		end

		// ************************************************************
		// dead time and pins
		// ************************************************************
		for (int c = 0; c < `CH_N; c++) begin
			if (s.ctrl.dead_time_disable) begin
				next_s.dead_time_timer[c] = `DT_IDLE;
			end else if (next_s.phase_ff[c] != s.phase_ff[c]) begin
				// reload..0 then FFF: reload+1 cycles
				next_s.dead_time_timer[c] = s.dead_time_reload;
			end else if (s.dead_time_timer[c] != `DT_IDLE) begin
				next_s.dead_time_timer[c] = s.dead_time_timer[c] -
					`DT_W'(1);
			end
			// a phase shorter than dead time never turns on
			pos_act[c] = s.phase_ff[c] &&
				(s.dead_time_timer[c] == `DT_IDLE);
			neg_act[c] = !s.phase_ff[c] &&
				(s.dead_time_timer[c] == `DT_IDLE);
			// active low by default: invert both
			next_s.pos_pin[c] = pos_act[c] ^ !s.omode.output_polarity_bit;
			next_s.neg_pin[c] = neg_act[c] ^ !s.omode.output_polarity_bit;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= '0;
			s.dead_time_timer <= {`CH_N{`DT_IDLE}};
			s.pos_pin <= '1;
			s.neg_pin <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// pins float until output mode drives them
	assign pwm_positive_oe_n = {`CH_N{!s.omode.pins_enable}};
	assign pwm_negative_oe_n = {`CH_N{!s.omode.pins_enable}};
	assign pwm_out_positive = s.pos_pin;
	assign pwm_out_negative = s.neg_pin;
	assign period_match_irq = s.period_irq;
	assign underflow_irq = s.under_irq;
	assign duty_match_irq = s.duty_irq;
	assign reg_rdata = s.rdata;

endmodule // sawtooth_pwm_dead_time

`default_nettype wire

/* verif/pwm_checker.sv */
// assertions on the ports of the sawtooth pwm block
// assumes pwm_cfg.svh on the include path; bound from the bench
`include "pwm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pwm_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// pins and events
	input wire logic [`CH_N-1:0] pwm_out_positive,
	input wire logic [`CH_N-1:0] pwm_out_negative,
	input wire logic [`CH_N-1:0] pwm_positive_oe_n,
	input wire logic [`CH_N-1:0] pwm_negative_oe_n,
	input wire logic period_match_irq,
	input wire logic underflow_irq,
	input wire logic [`CMP_N-1:0] duty_match_irq
);
	// ****************
	// properties
	// ****************
	logic om_wr;
	assign om_wr = reg_wr && reg_addr == `OFS_OUTPUT_MODE;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_irq_pulse: assert property (
		period_match_irq |=> !period_match_irq)
		else $error("period event too long");
	a_duty_pulse: assert property (
		duty_match_irq != 5'h00 |=>
		(duty_match_irq & $past(duty_match_irq)) == 5'h00)
		else $error("duty event too long");
	a_irq_exclusive: assert property (
		!(period_match_irq && underflow_irq))
		else $error("top and bottom events together");
	a_oe_pair: assert property (
		pwm_positive_oe_n == pwm_negative_oe_n)
		else $error("pin enables differ");
	a_reset_idle: assert property (
		$rose(rst_n) |-> pwm_positive_oe_n == 3'h7 &&
		pwm_out_positive == 3'h7 && pwm_out_negative == 3'h0 &&
		!period_match_irq)
		else $error("pins not idle after reset");
	a_oe_cause: assert property (
		$changed(pwm_positive_oe_n) |-> $past(om_wr) || $past(om_wr, 2))
		else $error("pin enable moved without write");
	a_reload_width: assert property (
		reg_rd && reg_addr == `OFS_DEAD_TIME_RELOAD |=>
		reg_rdata[31:12] == 20'h0_0000)
		else $error("reload wider than twelve bits");
	a_period_width: assert property (
		reg_rd && reg_addr == `OFS_PERIOD_BUFFER |=>
		reg_rdata[31:16] == 16'h0000)
		else $error("period wider than sixteen bits");

	c_period: cover property (period_match_irq);
	c_duty: cover property (duty_match_irq[0]);
	c_drive: cover property (pwm_positive_oe_n == 3'h0);
	c_bottom: cover property (underflow_irq);
endmodule // pwm_checker
`default_nettype wire

/* verif/pwm_gate_model.sv */
// gate drivers of three bridge legs on the six pwm pins
// assumes the bench tells it which level is active
`include "pwm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pwm_gate_model (
	// clock
	input wire logic mclk,
	// pins from the block
	input wire logic [`CH_N-1:0] pos,
	input wire logic [`CH_N-1:0] neg,
	input wire logic [`CH_N-1:0] oe_n,
	input wire logic active_high,
	// sticky fault
	output logic shoot_through
);
	logic [`CH_N-1:0] pos_on;
	logic [`CH_N-1:0] neg_on;
	assign pos_on = ~oe_n & (pos ~^ {`CH_N{active_high}});
	assign neg_on = ~oe_n & (neg ~^ {`CH_N{active_high}});
	// both switches on shorts the supply, so one cycle is already fatal
	initial begin
		shoot_through = 1'b0;
		forever begin
			@(posedge mclk);
			if ((pos_on & neg_on) != 3'h0) shoot_through <= 1'b1;
		end
	end
endmodule // pwm_gate_model
`default_nettype wire

/* verif/sawtooth_pwm_dead_time_bench.sv */
// self-checking bench for the sawtooth pwm block
// assumes the package, config header and gate model are compiled first
`include "pwm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sawtooth_pwm_dead_time_bench;
	logic mclk, rst_n, reg_wr, reg_rd, pol, st, period_match_irq;
	logic underflow_irq;
	logic [`ADDR_W-1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [`CH_N-1:0] pwm_out_positive, pwm_out_negative;
	logic [`CH_N-1:0] pwm_positive_oe_n, pwm_negative_oe_n;
	logic [`CMP_N-1:0] duty_match_irq;
	int err_count, check_count, p, r, k, d, dis;
	int wc, wn, wp, wu;

	sawtooth_pwm_dead_time #(.IS_UNIT0(1'b0)) i_dut (.mclk, .rst_n,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pwm_out_positive, .pwm_out_negative, .pwm_positive_oe_n,
		.pwm_negative_oe_n, .period_match_irq, .underflow_irq,
		.duty_match_irq);
	pwm_gate_model i_gate (.mclk, .pos(pwm_out_positive),
		.neg(pwm_out_negative), .oe_n(pwm_positive_oe_n),
		.active_high(pol), .shoot_through(st));

	// ****************
	// tasks
	// ****************
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= x;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		v = reg_rdata;
	endtask
	task automatic wait_irq(input bit under = 1'b0);
		@(negedge mclk);
		for (int i = 0; i < 1000 && (under ? underflow_irq :
			period_match_irq) !== 1'b1; i++)
			@(negedge mclk);
		if ((under ? underflow_irq : period_match_irq) !== 1'b1) begin
			err_count++;
			results();
		end
	endtask
	// active width less dead time, never below zero
	function automatic int exp_w(input int a, input int t);
		return a > t ? a - t : 0;
	endfunction
	task automatic measure();
		int c = 0, pp0 = 0, nn0 = 0, nn1 = 0, pp2 = 0, dc0 = 0, dc2 = 0;
		int t = dis ? 0 : r + 1;
		wait_irq();
		wait_irq();
		do begin
			@(negedge mclk);
			c++;
			pp0 += pwm_out_positive[0] === pol;
			nn0 += pwm_out_negative[0] === pol;
			nn1 += pwm_out_negative[1] === pol;
			pp2 += pwm_out_positive[2] === pol;
			dc0 += duty_match_irq[0] === 1'b1;
			dc2 += duty_match_irq[2] === 1'b1;
		end while (period_match_irq !== 1'b1 && c < 1000);
		chk("period", (p + 1) << k, c);
		chk("pos width", exp_w((d + 1) << k, t), pp0);
		chk("neg width", exp_w((p - d) << k, t), nn0);
		chk("duty at top", (p + 1) << k, nn1);
		chk("duty above top", (p + 1) << k, pp2);
		chk("duty event", 1, dc0);
		chk("event above top", 0, dc2);
	endtask

	// ****************
	// sequence
	// ****************
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		pol = 1'b0;
		err_count = 0;
		check_count = 0;
		v = $urandom(86879);
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk("enable after reset", 32'h0000_0007, 32'(pwm_positive_oe_n));
		rd(`OFS_DEAD_TIME_RELOAD);
		chk("reload reset", 32'h0000_0000, v);
		wr(8'h80, 32'hFFFF_FFFF);
		rd(8'h80);
		chk("unmapped read", 32'h0000_0000, v);
		pol = 1'b1;
		wr(`OFS_OUTPUT_MODE, 32'h0000_0003);
		repeat (3) @(negedge mclk);
		chk("idle levels", 32'h0000_0038, 32'({pwm_out_negative, pwm_out_positive}));
		for (int i = 0; i < 4; i++) begin
			p = 8 + $urandom % 13;
			r = $urandom % 3;
			k = $urandom % 3;
			d = r + 1 + $urandom % (p - 2 * r - 2);
			dis = i % 2;
			if (i == 0) begin // width not above dead time
				d = 0;
				k = 0;
			end
			wr(`OFS_TIMER_CONTROL, 32'h0000_0000);
			// pins off while the meaning of the levels changes
			wr(`OFS_OUTPUT_MODE, 32'h0000_0000);
			pol = i < 2;
			wr(`OFS_OUTPUT_MODE, {30'h0, 1'b1, pol});
			wr(`OFS_PERIOD_BUFFER, 32'(p));
			wr(`OFS_DUTY_BUFFER_0, 32'(d));
			wr(`OFS_DUTY_BUFFER_0 + 8'h04, 32'(p));
			wr(`OFS_DUTY_BUFFER_0 + 8'h08, 32'(p + 1));
			wr(`OFS_DEAD_TIME_RELOAD, 32'(r));
			wr(`OFS_TIMER_CONTROL, {23'h0, 1'b1, dis[0], 2'b00, k[2:0],
				pwm_pkg::MODE_SAW});
			measure();
		end
		wr(`OFS_TIMER_CONTROL, {23'h0, 1'b1, 1'b0, 2'b01, 3'h0,
			pwm_pkg::MODE_SAW});
		wait_irq();
		wr(`OFS_PERIOD_BUFFER, 32'(p + 2));
		rd(`OFS_PERIOD_COMPARE);
		chk("compare held", 32'(p), v);
		wait_irq();
		rd(`OFS_PERIOD_COMPARE);
		chk("compare copied", 32'(p + 2), v);
		// asymmetric triangle: top-equal duty lands with the transfer
		wr(`OFS_TIMER_CONTROL, 32'h0000_0000);
		wr(`OFS_DUTY_BUFFER_0 + 8'h08, 32'(p + 3));
		wr(`OFS_TIMER_CONTROL, {23'h0, 1'b1, 1'b0, 2'b10, k[2:0],
			pwm_pkg::MODE_TRI_ASYM});
		wait_irq(1'b1);
		wr(`OFS_DUTY_BUFFER_0 + 8'h08, 32'(p + 2));
		wait_irq();
		wc = 0;
		wn = 0;
		wp = 0;
		wu = 0;
		do begin
			@(negedge mclk);
			wc++;
			wn += pwm_out_negative[2] === pol;
			wp += pwm_out_positive[2] === pol;
			wu += underflow_irq === 1'b1;
		end while (period_match_irq !== 1'b1 && wc < 1000);
		chk("tri period", (2 * p + 4) << k, wc);
		chk("top duty neg", exp_w((2 * p + 4) << k, r + 1), wn);
		chk("top duty pos", 0, wp);
		chk("bottom event", 1, wu);
		chk("leg overlap", 32'h0000_0000, 32'(st));
		results();
	end
endmodule // sawtooth_pwm_dead_time_bench

bind sawtooth_pwm_dead_time pwm_checker i_chk (.mclk, .rst_n, .reg_addr,
	.reg_wr, .reg_rd, .reg_rdata, .pwm_out_positive, .pwm_out_negative,
	.pwm_positive_oe_n, .pwm_negative_oe_n, .period_match_irq,
	.underflow_irq, .duty_match_irq);
`default_nettype wire
